// *** fdpc_pkg.sv ***
package fdpc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PIN_N = 8;
    localparam int IDX_W = 3;
    localparam int RAM_DEPTH = 8;

    localparam logic [ADDR_W-1:0] DIGIT_CTRL_ADDR = 8'hBB;
    localparam logic [ADDR_W-1:0] SCAN_STATUS_ADDR = 8'hA0;
    localparam logic [ADDR_W-1:0] FRAME_COUNT_ADDR = 8'hA1;
    localparam logic [ADDR_W-1:0] RAM_BASE_ADDR = 8'h90;
    localparam logic [ADDR_W-1:0] RAM_LAST_ADDR = 8'h97;

    localparam int ENABLE_BIT = 7;
    localparam int SEG_ON_BIT = 6;
    localparam int RESERVED_BIT = 5;
    localparam int SPARE_BIT = 4;
    localparam int SPLIT_MSB = 3;
    localparam int SPLIT_ALL_SEG_BIT = 3;
    localparam int SPLIT_COUNT_MSB = 2;

    localparam int STAT_RUN_BIT = 7;
    localparam int STAT_SHOW_BIT = 6;
    localparam int STAT_BLANK_BIT = 5;

    localparam logic [DATA_W-1:0] DIGIT_CTRL_RESET = 8'h20;
    localparam logic [3:0] SPLIT_RESET = 4'h0;
    localparam logic [DATA_W-1:0] RAM_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
    localparam logic [IDX_W-1:0] LAST_PIN = 3'h7;
    localparam logic [IDX_W-1:0] FIRST_WORD = 3'h0;

    localparam int CLOCK_PERIOD_NS = 40;
    localparam int DIGIT_TIME_NS = 40000;
    localparam int BLANK_TIME_NS = 2000;
    localparam int DIGIT_CYCLES = (DIGIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int BLANK_CYCLES = (BLANK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] DIGIT_LAST = CNT_W'(DIGIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] BLANK_LAST = CNT_W'(BLANK_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

    typedef enum logic [2:0] {
        SCAN_IDLE = 3'b001,
        SCAN_BLANK = 3'b010,
        SCAN_SHOW = 3'b100
    } fdpc_scan_state_type;

endpackage : fdpc_pkg

// *** fdpc_scan_if.sv ***
`timescale 1ns/1ns
interface fdpc_scan_if;
    logic run;
    logic [fdpc_pkg::IDX_W-1:0] firstDigit;
    logic noDigits;
    logic [fdpc_pkg::IDX_W-1:0] digitIdx;
    logic showing;
    logic blanking;
    logic frameDone;

    modport ctrl (
        output run,
        output firstDigit,
        output noDigits,
        input digitIdx,
        input showing,
        input blanking,
        input frameDone
    );

    modport scanner (
        input run,
        input firstDigit,
        input noDigits,
        output digitIdx,
        output showing,
        output blanking,
        output frameDone
    );
endinterface : fdpc_scan_if

// *** fdpc_scan.sv ***
`timescale 1ns/1ns
module fdpc_scan (
    input wire logic clock, // System clock
    input wire logic rst, // Asynchronous reset, active high
    fdpc_scan_if.scanner scan // Scan control and status
);

    fdpc_pkg::fdpc_scan_state_type state_q;
    logic [fdpc_pkg::CNT_W-1:0] cnt_q;
    logic [fdpc_pkg::IDX_W-1:0] idx_q;
    logic frameDone_q;
    logic phaseEnd;
    logic lastDigit;

    always_comb begin
        phaseEnd = 1'b0;
        unique case (state_q)
            fdpc_pkg::SCAN_IDLE: phaseEnd = 1'b0;
            fdpc_pkg::SCAN_BLANK: phaseEnd = (cnt_q == fdpc_pkg::BLANK_LAST);
            fdpc_pkg::SCAN_SHOW: phaseEnd = (cnt_q == fdpc_pkg::DIGIT_LAST);
            default: phaseEnd = 1'b0;
        endcase
    end

    assign lastDigit = (idx_q == fdpc_pkg::LAST_PIN) || scan.noDigits;

    // Disabled controller sits in its reset state, not just paused
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= fdpc_pkg::SCAN_IDLE;
        end else if (!scan.run) begin
            state_q <= fdpc_pkg::SCAN_IDLE;
        end else begin
            unique case (state_q)
                fdpc_pkg::SCAN_IDLE: state_q <= fdpc_pkg::SCAN_BLANK;
                fdpc_pkg::SCAN_BLANK: if (phaseEnd) state_q <= fdpc_pkg::SCAN_SHOW;
                fdpc_pkg::SCAN_SHOW: if (phaseEnd) state_q <= fdpc_pkg::SCAN_BLANK;
                default: state_q <= fdpc_pkg::SCAN_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= fdpc_pkg::CNT_ZERO;
        end else if (!scan.run || phaseEnd || state_q == fdpc_pkg::SCAN_IDLE) begin
            cnt_q <= fdpc_pkg::CNT_ZERO;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Split may change mid-scan; an index below the new first digit is pulled up
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idx_q <= fdpc_pkg::FIRST_WORD;
        end else if (!scan.run || state_q == fdpc_pkg::SCAN_IDLE) begin
            idx_q <= scan.firstDigit;
        end else if (idx_q < scan.firstDigit) begin
            idx_q <= scan.firstDigit;
        end else if (state_q == fdpc_pkg::SCAN_SHOW && phaseEnd) begin
            idx_q <= lastDigit ? scan.firstDigit : idx_q + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frameDone_q <= 1'b0;
        end else begin
            frameDone_q <= scan.run && state_q == fdpc_pkg::SCAN_SHOW && phaseEnd && lastDigit;
        end
    end

    assign scan.digitIdx = idx_q;
    assign scan.showing = (state_q == fdpc_pkg::SCAN_SHOW);
    assign scan.blanking = (state_q == fdpc_pkg::SCAN_BLANK);
    assign scan.frameDone = frameDone_q;

endmodule : fdpc_scan

// *** fdpc_top.sv ***
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module fdpc_top (
    input wire logic clock, // System clock, 25 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [fdpc_pkg::ADDR_W-1:0] regAddr, // Register address
    input wire logic [fdpc_pkg::DATA_W-1:0] regWrData, // Register write data
    input wire logic regWrite, // Write strobe
    input wire logic regRead, // Read strobe
    output logic [fdpc_pkg::DATA_W-1:0] regRdData, // Read data, cycle after strobe
    output logic [fdpc_pkg::PIN_N-1:0] gridPin, // Shared high-voltage pin drive
    output logic [fdpc_pkg::PIN_N-1:0] segmentPin // High where a pin acts as segment
);

    fdpc_scan_if scanBus ();

    logic displayDriverEnable_q;
    logic segmentOutputOn_q;
    logic spare_q;
    logic [fdpc_pkg::SPLIT_MSB:0] pinSplit_q;
    logic [fdpc_pkg::DATA_W-1:0] dispRam_q [fdpc_pkg::RAM_DEPTH];
    logic [fdpc_pkg::DATA_W-1:0] frameCount_q;
    logic [fdpc_pkg::DATA_W-1:0] regRdData_q;
    logic [fdpc_pkg::PIN_N-1:0] gridPin_q;
    logic [fdpc_pkg::PIN_N-1:0] segmentPin_q;

    logic ctrlHit;
    logic ramHit;
    logic statusHit;
    logic frameHit;
    logic [fdpc_pkg::IDX_W-1:0] ramIdx;
    logic allSegments;
    logic [fdpc_pkg::IDX_W-1:0] segCount;
    logic [fdpc_pkg::IDX_W-1:0] curWord;
    logic [fdpc_pkg::DATA_W-1:0] curData;
    logic [fdpc_pkg::DATA_W-1:0] ctrlView;
    logic [fdpc_pkg::DATA_W-1:0] statusView;
    logic [fdpc_pkg::DATA_W-1:0] rdMux;
    logic [fdpc_pkg::PIN_N-1:0] pinRole;
    logic [fdpc_pkg::PIN_N-1:0] pinDrive;

    // Address decode
    assign ctrlHit = (regAddr == fdpc_pkg::DIGIT_CTRL_ADDR);
    assign statusHit = (regAddr == fdpc_pkg::SCAN_STATUS_ADDR);
    assign frameHit = (regAddr == fdpc_pkg::FRAME_COUNT_ADDR);
    assign ramHit = (regAddr >= fdpc_pkg::RAM_BASE_ADDR) && (regAddr <= fdpc_pkg::RAM_LAST_ADDR);
    assign ramIdx = fdpc_pkg::IDX_W'(regAddr - fdpc_pkg::RAM_BASE_ADDR);

    // Control register: enable, segment drive, spare bit and pin split
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            displayDriverEnable_q <= fdpc_pkg::DIGIT_CTRL_RESET[fdpc_pkg::ENABLE_BIT];
            segmentOutputOn_q <= fdpc_pkg::DIGIT_CTRL_RESET[fdpc_pkg::SEG_ON_BIT];
            spare_q <= fdpc_pkg::DIGIT_CTRL_RESET[fdpc_pkg::SPARE_BIT];
            pinSplit_q <= fdpc_pkg::SPLIT_RESET;
        end else if (regWrite && ctrlHit) begin
            displayDriverEnable_q <= regWrData[fdpc_pkg::ENABLE_BIT];
            segmentOutputOn_q <= regWrData[fdpc_pkg::SEG_ON_BIT];
            spare_q <= regWrData[fdpc_pkg::SPARE_BIT];
            pinSplit_q <= regWrData[fdpc_pkg::SPLIT_MSB:0];
        end
    end

    // Display memory is kept through disable and segment-off alike
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < fdpc_pkg::RAM_DEPTH; i++) begin
                dispRam_q[i] <= fdpc_pkg::RAM_RESET;
            end
        end else if (regWrite && ramHit) begin
            dispRam_q[ramIdx] <= regWrData;
        end
    end

    // Completed scan frames, cleared while the controller is held in reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frameCount_q <= fdpc_pkg::READ_IDLE;
        end else if (!displayDriverEnable_q) begin
            frameCount_q <= fdpc_pkg::READ_IDLE;
        end else if (scanBus.frameDone) begin
            frameCount_q <= frameCount_q + 1'b1;
        end
    end

    // Scan sequencer hookup
    assign scanBus.run = displayDriverEnable_q;
    assign allSegments = pinSplit_q[fdpc_pkg::SPLIT_ALL_SEG_BIT];
    assign segCount = pinSplit_q[fdpc_pkg::SPLIT_COUNT_MSB:0];
    assign scanBus.firstDigit = allSegments ? fdpc_pkg::LAST_PIN : segCount;
    assign scanBus.noDigits = allSegments;

    fdpc_scan scanUnit (
        .clock (clock),
        .rst (rst),
        .scan (scanBus.scanner)
    );

    // Without digits there is nothing to scan, so word 0 drives the segments
    assign curWord = allSegments ? fdpc_pkg::FIRST_WORD : scanBus.digitIdx;
    assign curData = dispRam_q[curWord];

    // Per pin: segment FS(7-i) below the split, digit strobe at or above it
    genvar p;
    generate
        for (p = 0; p < fdpc_pkg::PIN_N; p++) begin : gPin
            localparam logic [fdpc_pkg::IDX_W-1:0] PIN_IDX = fdpc_pkg::IDX_W'(p);
            localparam int SEG_BIT = fdpc_pkg::PIN_N - 1 - p;

            always_comb begin
                pinRole[p] = allSegments || (PIN_IDX < segCount);
                if (!displayDriverEnable_q) begin
                    pinDrive[p] = 1'b0;
                end else if (pinRole[p]) begin
                    // Blanked between digits so one digit's pattern never ghosts onto the next
                    pinDrive[p] = segmentOutputOn_q && curData[SEG_BIT]
                        && (scanBus.showing || allSegments);
                end else begin
                    // Digits keep scanning whatever the segment bit says
                    pinDrive[p] = scanBus.showing && (scanBus.digitIdx == PIN_IDX);
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gridPin_q <= {fdpc_pkg::PIN_N{1'b0}};
        end else begin
            gridPin_q <= pinDrive;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            segmentPin_q <= {fdpc_pkg::PIN_N{1'b0}};
        end else begin
            segmentPin_q <= pinRole;
        end
    end

    // Read views; reserved bit 5 reads as one
    always_comb begin
        ctrlView = fdpc_pkg::READ_IDLE;
        ctrlView[fdpc_pkg::ENABLE_BIT] = displayDriverEnable_q;
        ctrlView[fdpc_pkg::SEG_ON_BIT] = segmentOutputOn_q;
        ctrlView[fdpc_pkg::RESERVED_BIT] = fdpc_pkg::DIGIT_CTRL_RESET[fdpc_pkg::RESERVED_BIT];
        ctrlView[fdpc_pkg::SPARE_BIT] = spare_q;
        ctrlView[fdpc_pkg::SPLIT_MSB:0] = pinSplit_q;
    end

    always_comb begin
        statusView = fdpc_pkg::READ_IDLE;
        statusView[fdpc_pkg::STAT_RUN_BIT] = displayDriverEnable_q;
        statusView[fdpc_pkg::STAT_SHOW_BIT] = scanBus.showing;
        statusView[fdpc_pkg::STAT_BLANK_BIT] = scanBus.blanking;
        statusView[fdpc_pkg::IDX_W-1:0] = scanBus.digitIdx;
    end

    always_comb begin
        if (ctrlHit) begin
            rdMux = ctrlView;
        end else if (statusHit) begin
            rdMux = statusView;
        end else if (frameHit) begin
            rdMux = frameCount_q;
        end else if (ramHit) begin
            rdMux = dispRam_q[ramIdx];
        end else begin
            rdMux = fdpc_pkg::READ_IDLE;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdData_q <= fdpc_pkg::READ_IDLE;
        end else if (regRead) begin
            regRdData_q <= rdMux;
        end else begin
            regRdData_q <= fdpc_pkg::READ_IDLE;
        end
    end

    assign regRdData = regRdData_q;
    assign gridPin = gridPin_q;
    assign segmentPin = segmentPin_q;

endmodule : fdpc_top

// *** fdpc_top_monitor.sv ***
`timescale 1ns/1ns
module fdpc_top_monitor (
    input wire logic clock, // System clock
    input wire logic rst, // Async reset
    input wire logic [7:0] regAddr, // Address
    input wire logic [7:0] regWrData, // Write data
    input wire logic regWrite, // Write strobe
    input wire logic regRead, // Read strobe
    input wire logic [7:0] regRdData, // Read data
    input wire logic [7:0] gridPin, // Pin drive
    input wire logic [7:0] segmentPin // Segment mask
);
    logic [7:0] ctlShadow_q;
    logic [3:0] quiet_q;
    logic [7:0] digitPins;
    logic ctlWrite;
    logic settled;
    logic mapped;
    assign digitPins = gridPin & ~segmentPin;
    assign ctlWrite = regWrite && regAddr == fdpc_pkg::DIGIT_CTRL_ADDR;
    assign settled = quiet_q >= 4'h3;
    assign mapped = regAddr == fdpc_pkg::DIGIT_CTRL_ADDR || regAddr == fdpc_pkg::SCAN_STATUS_ADDR
        || regAddr == fdpc_pkg::FRAME_COUNT_ADDR || regAddr[7:3] == 5'h12;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctlShadow_q <= fdpc_pkg::DIGIT_CTRL_RESET;
        end else if (ctlWrite) begin
            ctlShadow_q <= regWrData | 8'h20;
        end
    end
    // Pin outputs lag the register, so checks wait for a quiet spell
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            quiet_q <= 4'h0;
        end else if (ctlWrite) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    function automatic logic [7:0] splitMask(input logic [3:0] s);
        return s[3] ? 8'hFF : ~(8'hFF << s[2:0]);
    endfunction : splitMask
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence digitShown;
        digitPins != 8'h00 || quiet_q == 4'h0;
    endsequence
    chk_read_answer: assert property (regRead && regAddr == fdpc_pkg::DIGIT_CTRL_ADDR |=> regRdData == ctlShadow_q)
        else $error("control read back differs");
    chk_read_idle: assert property (!regRead |=> regRdData == 8'h00)
        else $error("read data outside answer cycle");
    chk_unmapped_zero: assert property (regRead && !mapped |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    chk_disable_dark: assert property (!ctlShadow_q[7] && !$past(ctlShadow_q[7]) |-> gridPin == 8'h00)
        else $error("pins driven while disabled");
    chk_seg_dark: assert property (settled && !ctlShadow_q[6] |-> (gridPin & segmentPin) == 8'h00)
        else $error("segment lit while output off");
    chk_split_mask: assert property (settled |-> segmentPin == splitMask(ctlShadow_q[3:0]))
        else $error("segment mask wrong for split");
    chk_one_digit: assert property (settled |-> $onehot0(digitPins))
        else $error("more than one digit lit");
    chk_scan_alive: assert property (settled && ctlShadow_q[7] && !ctlShadow_q[3] |-> ##[0:60] digitShown)
        else $error("digit scan stalled");
endmodule : fdpc_top_monitor
bind fdpc_top fdpc_top_monitor fdpc_top_monitor_i (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .gridPin(gridPin), .segmentPin(segmentPin));

// *** fdpc_glass.sv ***
`timescale 1ns/1ns
module fdpc_glass (
    input wire logic [7:0] gridPin, // Pin drive
    input wire logic [7:0] segmentPin, // Segment mask
    output logic [7:0] segGlow, // Lit anodes by segment number
    output logic [2:0] digitLit, // Highest lit grid
    output logic anyDigit // Some grid lit
);
    always_comb begin
        anyDigit = 1'b0;
        digitLit = 3'h0;
        for (int i = 0; i < 8; i++) begin
            segGlow[7 - i] = gridPin[i] & segmentPin[i];
            if ((gridPin[i] & ~segmentPin[i]) == 1'b1) begin
                anyDigit = 1'b1;
                digitLit = 3'(i);
            end
        end
    end
endmodule : fdpc_glass

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
    localparam logic [7:0] CTL = fdpc_pkg::DIGIT_CTRL_ADDR;
    localparam logic [7:0] RAM = fdpc_pkg::RAM_BASE_ADDR;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdData, gridPin, segmentPin, segGlow;
    logic [2:0] digitLit;
    logic anyDigit;
    logic [7:0] words [8];
    int seed = 4;
    int n_mismatch = 0;
    int tests_run = 0;
    always #20 clock = ~clock;
    fdpc_top fdpc_top_i (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .gridPin(gridPin),
        .segmentPin(segmentPin));
    fdpc_glass fdpc_glass_i (.gridPin(gridPin), .segmentPin(segmentPin), .segGlow(segGlow),
        .digitLit(digitLit), .anyDigit(anyDigit));
    task automatic print_verdict;
        $display("Counts: tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask : rdChk
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle
    // A timeout leaves a non-matching sample, so the compare catches it
    task automatic waitDigit(input logic [2:0] n);
        for (int k = 0; k < 1200; k++) begin
            settle(1);
            if (anyDigit === 1'b1 && digitLit === n) break;
        end
        chk({4'h0, anyDigit, digitLit}, {4'h0, 1'b1, n});
    endtask : waitDigit
    function automatic logic [7:0] topMask(input logic [2:0] k);
        return ~(8'hFF >> k);
    endfunction : topMask
    function automatic logic [7:0] pinMask(input logic [3:0] s);
        return s[3] ? 8'hFF : ~(8'hFF << s[2:0]);
    endfunction : pinMask
    initial begin
        repeat (40000) @(posedge clock);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rdChk(CTL, fdpc_pkg::DIGIT_CTRL_RESET);
        chk(gridPin, 8'h00);
        rdChk(8'h55, 8'h00);
        for (int i = 0; i < 8; i++) begin
            words[i] = 8'($random(seed));
            wr(RAM + 8'(i), words[i]);
        end
        wr(CTL, 8'hD6);
        rdChk(CTL, 8'hF6);
        waitDigit(3'h6);
        chk(segGlow, words[6] & topMask(3'h6));
        rdChk(fdpc_pkg::SCAN_STATUS_ADDR, 8'hC6);
        waitDigit(3'h7);
        chk(segGlow, words[7] & topMask(3'h6));
        wr(CTL, 8'h96);
        waitDigit(3'h6);
        chk(segGlow, 8'h00);
        rdChk(CTL, 8'hB6);
        rdChk(fdpc_pkg::FRAME_COUNT_ADDR, 8'h01);
        for (int i = 0; i < 8; i++) rdChk(RAM + 8'(i), words[i]);
        for (int k = 0; k < 16; k++) begin
            wr(CTL, 8'hC0 | 8'(k));
            settle(4);
            chk(segmentPin, pinMask(4'(k)));
            if (k > 7) chk(segGlow, words[0]);
        end
        // Memory rewrite while segments are shown statically
        words[0] = 8'($random(seed));
        wr(RAM, words[0]);
        settle(3);
        chk(segGlow, words[0]);
        wr(CTL, 8'h48);
        settle(3);
        chk(gridPin, 8'h00);
        rdChk(fdpc_pkg::FRAME_COUNT_ADDR, 8'h00);
        rdChk(RAM, words[0]);
        wr(CTL, 8'hC8);
        settle(4);
        chk(segGlow, words[0]);
        print_verdict;
    end
endmodule : testbench
